// ==== shared/adc_cfg_pkg.sv ====
// Constants for the converter configuration register slice.
// Assumes byte-wide serial register access with 15-bit byte addresses.
`default_nettype none
package adc_cfg_pkg;

    // Serial frame layout
    localparam int ADDR_W = 15;                          // Byte address width
    localparam int DATA_W = 8;                           // Data byte width
    localparam int FRAME_BITS = 24;                      // Bits in one access frame
    localparam int ADDR_DONE_BITS = 16;                  // Bits up to the end of the address
    localparam int CNT_W = 5;                            // Frame bit counter width

    // Byte offsets
    localparam logic [14:0] OFS_CLOCK_SELECT = 15'h0029;  // Clock control holding the SYSREF delay pick
    localparam logic [14:0] OFS_NOISE_CTRL = 15'h002B;    // clock_noise_control
    localparam logic [14:0] OFS_EDGE_POS0 = 15'h002C;     // sysref_edge_position bits 7:0
    localparam logic [14:0] OFS_EDGE_POS1 = 15'h002D;     // sysref_edge_position bits 15:8
    localparam logic [14:0] OFS_EDGE_POS2 = 15'h002E;     // sysref_edge_position bits 23:16
    localparam logic [14:0] OFS_SPAN_LO = 15'h0030;       // fullscale_span bits 7:0
    localparam logic [14:0] OFS_SPAN_HI = 15'h0031;       // fullscale_span bits 15:8
    localparam logic [14:0] OFS_POWER_PROFILE = 15'h0037; // power_profile_code
    localparam logic [14:0] OFS_TIMESTAMP = 15'h003B;     // timestamp_input_control

    // Reset values
    localparam logic [7:0] RST_CLOCK_SELECT = 8'h80;      // Reserved top bit set
    localparam logic [7:0] RST_NOISE_CTRL = 8'h10;        // Reserved bit 4 set
    localparam logic [15:0] RST_SPAN = 16'hA000;          // Middle span
    localparam logic [7:0] RST_POWER_PROFILE = 8'h4B;     // High performance
    localparam logic [7:0] RST_TIMESTAMP = 8'h00;         // Input off
    localparam logic [23:0] RST_EDGE_POS = 24'h00_0000;   // Edge position before first capture

    // Power profile codes
    localparam logic [7:0] PROFILE_LOW_POWER = 8'h46;     // Only up to 1 GSPS
    localparam logic [7:0] PROFILE_HIGH_PERF = 8'h4B;     // Default

    // Field positions
    localparam int BIT_ANALOG_QUIET = 2;                  // Analog supply quieting
    localparam int BIT_CLOCK_QUIET = 0;                   // Clock supply quieting
    localparam int BIT_TS_TERM = 1;                       // Timestamp termination mode
    localparam int BIT_TS_RECV = 0;                       // Timestamp receiver on
    localparam int DELAY_PICK_MSB = 3;                    // SYSREF delay pick top bit

    // Frame states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE = 3'b100
    } frame_state_t;

endpackage
`default_nettype wire

// ==== shared/reg_access_if.sv ====
// Register access carrier between the serial front end and the register bank.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
    logic [14:0] addr;   // Byte address of the access
    logic [7:0] wdata;   // Write byte
    logic wr;            // One-cycle write strobe
    logic [7:0] rdata;   // Read byte for addr, combinational

    // Serial side drives the access
    modport front (output addr, output wdata, output wr, input rdata);
    // Bank side answers it
    modport bank (input addr, input wdata, input wr, output rdata);
endinterface
`default_nettype wire

// ==== rtl/serial_front.sv ====
// Serial port front end: turns frames into byte register accesses.
// Assumes sclk, cs_n and sdi are synchronous to clk_sys and sclk is at most clk_sys/4.
`timescale 1ns/1ps
`default_nettype none
module serial_front
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    reg_access_if.front acc
);
    adc_cfg_pkg::frame_state_t state, next_state;   // Frame progress
    logic [4:0] cnt, next_cnt;                      // Bits received
    logic [23:0] shreg, next_shreg;                 // Incoming bits
    logic [7:0] outsh, next_outsh;                  // Outgoing read byte
    logic is_read, next_is_read;                    // Frame is a read
    logic load, next_load;                          // Read byte load pending
    logic sclk_d, next_sclk_d;                      // Previous sclk
    logic [14:0] addr, next_addr;                   // Latched address
    logic [7:0] wdata, next_wdata;                  // Latched write byte
    logic wr, next_wr;                              // Write strobe
    logic oe_n, next_oe_n;                          // Output enable, low drives
    logic rise;                                     // sclk rising edge
    logic fall;                                     // sclk falling edge

    assign rise = sclk & ~sclk_d;
    assign fall = ~sclk & sclk_d;

    // Frame decoding next state
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_outsh = outsh;
        next_is_read = is_read;
        next_load = 1'b0;
        next_sclk_d = sclk;
        next_addr = addr;
        next_wdata = wdata;
        next_wr = 1'b0;
        next_oe_n = oe_n;
        if (cs_n)
        begin
            // Deselect aborts any frame
            next_state = adc_cfg_pkg::ST_IDLE;
            next_cnt = 5'h0;
            next_oe_n = 1'b1;
        end
        else
        begin
            unique case (state)
                adc_cfg_pkg::ST_IDLE:
                begin
                    next_state = adc_cfg_pkg::ST_SHIFT;
                    next_cnt = 5'h0;
                end
                adc_cfg_pkg::ST_SHIFT:
                begin
                    if (rise)
                    begin
                        // Sample one bit, MSB first
                        next_shreg = {shreg[22:0], sdi};
                        next_cnt = cnt + 5'h1;
                        if (cnt == 5'(adc_cfg_pkg::ADDR_DONE_BITS - 1))
                        begin
                            // Address complete: latch it, fetch read byte
                            next_addr = {shreg[13:0], sdi};
                            next_is_read = shreg[14];
                            next_load = shreg[14];
                        end
                        if (cnt == 5'(adc_cfg_pkg::FRAME_BITS - 1))
                        begin
                            next_state = adc_cfg_pkg::ST_DONE;
                            next_wdata = {shreg[6:0], sdi};
                            next_wr = ~is_read;
                        end
                    end
                    if (load)
                    begin
                        // Byte ready before the first falling edge
                        next_outsh = acc.rdata;
                        next_oe_n = 1'b0;
                    end
                    else if (fall && !oe_n)
                    begin
                        next_outsh = {outsh[6:0], 1'b0};
                    end
                end
                adc_cfg_pkg::ST_DONE:
                begin
                    // Extra clocks until deselect are ignored
                    if (fall)
                    begin
                        next_oe_n = 1'b1;
                    end
                end
                default:
                begin
                    next_state = adc_cfg_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Frame decoding registers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state <= adc_cfg_pkg::ST_IDLE;
            cnt <= 5'h0;
            shreg <= 24'h00_0000;
            outsh <= 8'h00;
            is_read <= 1'b0;
            load <= 1'b0;
            sclk_d <= 1'b0;
            addr <= 15'h0000;
            wdata <= 8'h00;
            wr <= 1'b0;
            oe_n <= 1'b1;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            outsh <= next_outsh;
            is_read <= next_is_read;
            load <= next_load;
            sclk_d <= next_sclk_d;
            addr <= next_addr;
            wdata <= next_wdata;
            wr <= next_wr;
            oe_n <= next_oe_n;
        end
    end

    assign sdo = outsh[7];
    assign sdo_oe_n = oe_n;
    assign acc.addr = addr;
    assign acc.wdata = wdata;
    assign acc.wr = wr;

    // Write strobe lasts one cycle only
    property p_wr_single;
        @(posedge clk_sys) disable iff (!rst_n) wr |=> !wr;
    endproperty
    a_wr_single: assert property (p_wr_single) else $error("write strobe longer than one cycle");

    // A read frame never raises a write strobe
    property p_read_no_wr;
        @(posedge clk_sys) disable iff (!rst_n) (state == adc_cfg_pkg::ST_SHIFT) && is_read && !cs_n |=> !wr;
    endproperty
    a_read_no_wr: assert property (p_read_no_wr) else $error("read frame produced a write");

    c_write: cover property (@(posedge clk_sys) disable iff (!rst_n) wr);
    c_read: cover property (@(posedge clk_sys) disable iff (!rst_n) load);

endmodule // serial_front
`default_nettype wire

// ==== rtl/adc_cfg_regs.sv ====
// Configuration register slice: clock noise, SYSREF position, span, power profile, timestamp.
// Assumes a host on the serial port and analog status arriving synchronous to clk_sys.
//
// Functional notes
// - Bit 2 enables analog supply quieting
// - Bit 0 enables clock supply quieting
// - Read-only 24-bit SYSREF edge position status
// - 16-bit span, reset A000, all channels
// - Power profile resets 4B; 46 low power
// - Timestamp control: bit1 termination, bit0 receiver
// - Receiver bit gates the timestamp input
// - Four-bit SYSREF delay pick, separate register
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_regs
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    input wire logic [23:0] sysref_edge_position,
    input wire logic timestamp_in,
    output logic timestamp_gated,
    output logic analog_supply_quiet_en,
    output logic clock_supply_quiet_en,
    output logic [3:0] sysref_delay_pick,
    output logic [15:0] fullscale_span,
    output logic [7:0] power_profile_code,
    output logic power_profile_low,
    output logic timestamp_termination_mode,
    output logic timestamp_receiver_on
);
    reg_access_if acc();                                 // Access carrier

    logic [7:0] clock_select, next_clock_select;         // Holds the SYSREF delay pick
    logic [7:0] clock_noise_control, next_clock_noise_control;
    logic [15:0] span, next_span;                        // Shared full-scale span
    logic [7:0] profile, next_profile;                   // Power profile code
    logic [7:0] timestamp_input_control, next_timestamp_input_control;
    logic [23:0] pos, next_pos;                          // Captured edge position
    logic ts_gate, next_ts_gate;                         // Gated timestamp
    logic [7:0] rdata;                                   // Read mux result

    // Serial port front end
    serial_front u_front
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sclk(sclk),
        .cs_n(cs_n),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe_n(sdo_oe_n),
        .acc(acc)
    );

    // Register write next values
    always_comb
    begin
        next_clock_select = clock_select;
        next_clock_noise_control = clock_noise_control;
        next_span = span;
        next_profile = profile;
        next_timestamp_input_control = timestamp_input_control;
        if (acc.wr)
        begin
            unique case (acc.addr)
                // Whole byte stored; reserved bits kept as written
                adc_cfg_pkg::OFS_CLOCK_SELECT: next_clock_select = acc.wdata;
                adc_cfg_pkg::OFS_NOISE_CTRL: next_clock_noise_control = acc.wdata;
                adc_cfg_pkg::OFS_SPAN_LO: next_span[7:0] = acc.wdata;
                adc_cfg_pkg::OFS_SPAN_HI: next_span[15:8] = acc.wdata;
                // Any code stored; reserved codes are the host's concern
                adc_cfg_pkg::OFS_POWER_PROFILE: next_profile = acc.wdata;
                adc_cfg_pkg::OFS_TIMESTAMP: next_timestamp_input_control = acc.wdata;
                // Status bytes and unmapped addresses ignore writes
                default:
                begin
                    next_clock_select = clock_select;
                end
            endcase
        end
    end

    // Status capture and timestamp gating next values
    always_comb
    begin
        next_pos = sysref_edge_position;
        // Input switched off while receiver bit clear
        next_ts_gate = timestamp_in & timestamp_input_control[adc_cfg_pkg::BIT_TS_RECV];
    end

    // Register file flops
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            clock_select <= adc_cfg_pkg::RST_CLOCK_SELECT;
            clock_noise_control <= adc_cfg_pkg::RST_NOISE_CTRL;
            span <= adc_cfg_pkg::RST_SPAN;
            profile <= adc_cfg_pkg::RST_POWER_PROFILE;
            timestamp_input_control <= adc_cfg_pkg::RST_TIMESTAMP;
            pos <= adc_cfg_pkg::RST_EDGE_POS;
            ts_gate <= 1'b0;
        end
        else
        begin
            clock_select <= next_clock_select;
            clock_noise_control <= next_clock_noise_control;
            span <= next_span;
            profile <= next_profile;
            timestamp_input_control <= next_timestamp_input_control;
            pos <= next_pos;
            ts_gate <= next_ts_gate;
        end
    end

    // Read mux, byte per address, little endian for wide registers
    always_comb
    begin
        unique case (acc.addr)
            adc_cfg_pkg::OFS_CLOCK_SELECT: rdata = clock_select;
            adc_cfg_pkg::OFS_NOISE_CTRL: rdata = clock_noise_control;
            adc_cfg_pkg::OFS_EDGE_POS0: rdata = pos[7:0];
            adc_cfg_pkg::OFS_EDGE_POS1: rdata = pos[15:8];
            adc_cfg_pkg::OFS_EDGE_POS2: rdata = pos[23:16];
            adc_cfg_pkg::OFS_SPAN_LO: rdata = span[7:0];
            adc_cfg_pkg::OFS_SPAN_HI: rdata = span[15:8];
            adc_cfg_pkg::OFS_POWER_PROFILE: rdata = profile;
            adc_cfg_pkg::OFS_TIMESTAMP: rdata = timestamp_input_control;
            // Unmapped reads as zero
            default: rdata = 8'h00;
        endcase
    end
    assign acc.rdata = rdata;

    // Control outputs from register bits
    assign analog_supply_quiet_en = clock_noise_control[adc_cfg_pkg::BIT_ANALOG_QUIET];
    assign clock_supply_quiet_en = clock_noise_control[adc_cfg_pkg::BIT_CLOCK_QUIET];
    assign sysref_delay_pick = clock_select[adc_cfg_pkg::DELAY_PICK_MSB:0];
    assign fullscale_span = span;
    assign power_profile_code = profile;
    assign power_profile_low = (profile == adc_cfg_pkg::PROFILE_LOW_POWER);
    assign timestamp_termination_mode = timestamp_input_control[adc_cfg_pkg::BIT_TS_TERM];
    assign timestamp_receiver_on = timestamp_input_control[adc_cfg_pkg::BIT_TS_RECV];
    assign timestamp_gated = ts_gate;

    // Analog quieting follows the written bit 2
    property p_analog_quiet;
        @(posedge clk_sys) disable iff (!rst_n)
            acc.wr && acc.addr == adc_cfg_pkg::OFS_NOISE_CTRL |=> analog_supply_quiet_en == $past(acc.wdata[2]);
    endproperty
    a_analog_quiet: assert property (p_analog_quiet) else $error("analog quieting bit not taken");

    // Clock quieting follows the written bit 0
    property p_clock_quiet;
        @(posedge clk_sys) disable iff (!rst_n)
            acc.wr && acc.addr == adc_cfg_pkg::OFS_NOISE_CTRL |=> clock_supply_quiet_en == $past(acc.wdata[0]);
    endproperty
    a_clock_quiet: assert property (p_clock_quiet) else $error("clock quieting bit not taken");

    // Middle status byte reads the captured position one cycle late
    property p_pos_read;
        @(posedge clk_sys) disable iff (!rst_n)
            acc.addr == adc_cfg_pkg::OFS_EDGE_POS1 ##1 acc.addr == adc_cfg_pkg::OFS_EDGE_POS1
            |-> acc.rdata == $past(sysref_edge_position[15:8]);
    endproperty
    a_pos_read: assert property (p_pos_read) else $error("edge position byte wrong");

    // Upper span byte write leaves the lower byte alone
    property p_span_hi;
        @(posedge clk_sys) disable iff (!rst_n)
            acc.wr && acc.addr == adc_cfg_pkg::OFS_SPAN_HI
            |=> fullscale_span == {$past(acc.wdata), $past(fullscale_span[7:0])};
    endproperty
    a_span_hi: assert property (p_span_hi) else $error("span upper byte write wrong");

    // Profile code is high performance right after reset
    property p_profile_reset;
        @(posedge clk_sys) disable iff (!rst_n)
            !$past(rst_n) |-> power_profile_code == adc_cfg_pkg::PROFILE_HIGH_PERF && !power_profile_low;
    endproperty
    a_profile_reset: assert property (p_profile_reset) else $error("profile reset value wrong");

    // Termination mode follows the written bit 1
    property p_ts_term;
        @(posedge clk_sys) disable iff (!rst_n)
            acc.wr && acc.addr == adc_cfg_pkg::OFS_TIMESTAMP |=> timestamp_termination_mode == $past(acc.wdata[1]);
    endproperty
    a_ts_term: assert property (p_ts_term) else $error("termination bit not taken");

    // Receiver clear for two cycles keeps the gated input quiet the next cycle
    property p_ts_off;
        @(posedge clk_sys) disable iff (!rst_n)
            !timestamp_receiver_on [*2] |=> !timestamp_gated;
    endproperty
    a_ts_off: assert property (p_ts_off) else $error("timestamp passed while receiver off");

    // Delay pick follows the low nibble written
    property p_delay_pick;
        @(posedge clk_sys) disable iff (!rst_n)
            acc.wr && acc.addr == adc_cfg_pkg::OFS_CLOCK_SELECT |=> sysref_delay_pick == $past(acc.wdata[3:0]);
    endproperty
    a_delay_pick: assert property (p_delay_pick) else $error("delay pick not taken");

    // Profile holds while not written
    property p_profile_hold;
        @(posedge clk_sys) disable iff (!rst_n)
            !(acc.wr && acc.addr == adc_cfg_pkg::OFS_POWER_PROFILE) |=> $stable(power_profile_code);
    endproperty
    a_profile_hold: assert property (p_profile_hold) else $error("profile changed without a write");

    c_low_power: cover property (@(posedge clk_sys) disable iff (!rst_n) power_profile_low);
    c_ts_pass: cover property (@(posedge clk_sys) disable iff (!rst_n) timestamp_gated);
    c_span_min: cover property (@(posedge clk_sys) disable iff (!rst_n) fullscale_span == 16'h2000);

endmodule // adc_cfg_regs
`default_nettype wire

// ==== sim/host_spi_model.sv ====
// Host controller model: drives one-byte frames on the serial register port.
// Assumes the device samples sclk on clk_sys and drives sdo only while sdo_oe_n is low.
`timescale 1ns/1ps
`default_nettype none
module host_spi_model
(
    input wire logic clk_sys,
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    logic sdo_last = 1'b0; // Last level the device drove
    logic sdo_line; // Level the host sees on the data line

    // Idle port at time zero, clock parked low
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // A released line shows the inverse of its last driven level
    assign sdo_line = sdo_oe_n ? ~sdo_last : sdo;

    // Remember what the device last drove
    always @(posedge clk_sys)
    begin
        if (!sdo_oe_n)
            sdo_last <= sdo;
    end

    // One frame, MSB first; fewer than 24 bits aborts it
    task automatic frame(input logic rd, input logic [14:0] addr, input logic [7:0] wd, input int nbits,
                         output logic [7:0] q);
        logic [23:0] word;
        word = {rd, addr, wd};
        q = 8'h00;
        @(negedge clk_sys);
        cs_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        for (int i = 23; i >= 24 - nbits; i--)
        begin
            sclk = 1'b0;
            sdi = word[i];
            repeat (4) @(negedge clk_sys);
            sclk = 1'b1;
            repeat (4) @(negedge clk_sys);
            // Read byte taken at the end of the high phases of word bits 8 down to 1
            if (i >= 1 && i <= 8)
                q[i - 1] = sdo_line;
        end
        sclk = 1'b0;
        repeat (4) @(negedge clk_sys);
        cs_n = 1'b1;
        sdi = ~sdi;
        repeat (4) @(negedge clk_sys);
    endtask
endmodule // host_spi_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the configuration register slice.
// Assumes host_spi_model drives the serial port; the bench drives the status inputs.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) \
    begin \
        tests_run++; \
        if ((got) !== (ex)) \
        begin \
            fail_count++; \
            $display("mismatch %s expected %h seen %h", nm, ex, got); \
        end \
    end
module tb_top;
    logic clk_sys = 1'b0; // System clock
    logic rst_n = 1'b0; // Reset, active low
    logic sclk, cs_n, sdi, sdo, sdo_oe_n; // Serial port
    logic [23:0] sysref_edge_position; // Status input
    logic timestamp_in, timestamp_gated; // Timestamp path
    logic analog_supply_quiet_en, clock_supply_quiet_en, power_profile_low; // Decoded controls
    logic timestamp_termination_mode, timestamp_receiver_on; // Timestamp controls
    logic [3:0] sysref_delay_pick; // Delay pick
    logic [15:0] fullscale_span; // Span
    logic [7:0] power_profile_code; // Profile
    int fail_count = 0; // Mismatches
    int tests_run = 0; // Comparisons

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    host_spi_model host (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
    adc_cfg_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n), .sysref_edge_position(sysref_edge_position), .timestamp_in(timestamp_in),
        .timestamp_gated(timestamp_gated), .analog_supply_quiet_en(analog_supply_quiet_en),
        .clock_supply_quiet_en(clock_supply_quiet_en), .sysref_delay_pick(sysref_delay_pick),
        .fullscale_span(fullscale_span), .power_profile_code(power_profile_code),
        .power_profile_low(power_profile_low), .timestamp_termination_mode(timestamp_termination_mode),
        .timestamp_receiver_on(timestamp_receiver_on));

    // Register byte write and read
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.frame(1'b0, a, d, 24, q);
    endtask
    task automatic rd(input logic [14:0] a, output logic [7:0] q);
        host.frame(1'b1, a, 8'h00, 24, q);
    endtask

    // Reset values at outputs and on read-back
    task automatic t_reset;
        logic [14:0] a [9] = '{15'h0029, 15'h002B, 15'h002C, 15'h002D, 15'h002E, 15'h0030, 15'h0031, 15'h0037,
                               15'h003B};
        logic [7:0] e [9] = '{8'h80, 8'h10, 8'h3C, 8'h5A, 8'hA5, 8'h00, 8'hA0, 8'h4B, 8'h00};
        logic [7:0] q;
        `CHECK("span out", 16'hA000, fullscale_span)
        `CHECK("profile out", 8'h4B, power_profile_code)
        `CHECK("quiet outs", 2'b00, {analog_supply_quiet_en, clock_supply_quiet_en})
        `CHECK("ts outs", 2'b00, {timestamp_termination_mode, timestamp_receiver_on})
        for (int i = 0; i < 9; i++)
        begin
            rd(a[i], q);
            `CHECK("reset read", e[i], q)
        end
    endtask

    // Quieting enables, reserved bit 4 kept by the host
    task automatic t_noise;
        logic [7:0] q;
        wr(adc_cfg_pkg::OFS_NOISE_CTRL, 8'h15);
        `CHECK("quiet both", 2'b11, {analog_supply_quiet_en, clock_supply_quiet_en})
        wr(adc_cfg_pkg::OFS_NOISE_CTRL, 8'h11);
        `CHECK("clock quiet", 2'b01, {analog_supply_quiet_en, clock_supply_quiet_en})
        rd(adc_cfg_pkg::OFS_NOISE_CTRL, q);
        `CHECK("noise read", 8'h11, q)
        wr(adc_cfg_pkg::OFS_NOISE_CTRL, 8'h14);
        `CHECK("analog quiet", 2'b10, {analog_supply_quiet_en, clock_supply_quiet_en})
    endtask

    // Position is read-only; host picks delay from it
    task automatic t_sysref;
        logic [7:0] q;
        wr(adc_cfg_pkg::OFS_EDGE_POS1, 8'hFF);
        rd(adc_cfg_pkg::OFS_EDGE_POS1, q);
        `CHECK("pos write ignored", 8'h5A, q)
        sysref_edge_position = 24'h0F_F081;
        rd(adc_cfg_pkg::OFS_EDGE_POS0, q);
        `CHECK("pos low byte", 8'h81, q)
        wr(adc_cfg_pkg::OFS_CLOCK_SELECT, {4'h8, q[3:0]});
        `CHECK("delay pick", 4'h1, sysref_delay_pick)
    endtask

    // Span bytes take effect separately, boundary values
    task automatic t_span;
        logic [7:0] q;
        wr(adc_cfg_pkg::OFS_SPAN_LO, 8'h00);
        wr(adc_cfg_pkg::OFS_SPAN_HI, 8'h20);
        `CHECK("span min", 16'h2000, fullscale_span)
        wr(adc_cfg_pkg::OFS_SPAN_LO, 8'hFF);
        `CHECK("span low only", 16'h20FF, fullscale_span)
        wr(adc_cfg_pkg::OFS_SPAN_HI, 8'hFF);
        rd(adc_cfg_pkg::OFS_SPAN_HI, q);
        `CHECK("span max", 16'hFFFF, fullscale_span)
        `CHECK("span hi read", 8'hFF, q)
    endtask

    // Profile codes: low power 46, reserved 47, high performance 4B
    task automatic t_profile;
        logic [7:0] q;
        wr(adc_cfg_pkg::OFS_POWER_PROFILE, 8'h46);
        `CHECK("low power", 9'h146, {power_profile_low, power_profile_code})
        wr(adc_cfg_pkg::OFS_POWER_PROFILE, 8'h47);
        rd(adc_cfg_pkg::OFS_POWER_PROFILE, q);
        `CHECK("reserved code", 9'h047, {power_profile_low, q})
        wr(adc_cfg_pkg::OFS_POWER_PROFILE, 8'h4B);
        `CHECK("high perf", 9'h04B, {power_profile_low, power_profile_code})
    endtask

    // Receiver enable gates the timestamp input
    task automatic t_timestamp;
        wr(adc_cfg_pkg::OFS_TIMESTAMP, 8'h01);
        `CHECK("ts recv", 2'b01, {timestamp_termination_mode, timestamp_receiver_on})
        timestamp_in = 1'b1;
        repeat (2) @(negedge clk_sys);
        `CHECK("ts gated on", 1'b1, timestamp_gated)
        wr(adc_cfg_pkg::OFS_TIMESTAMP, 8'h02);
        `CHECK("ts term", 2'b10, {timestamp_termination_mode, timestamp_receiver_on})
        `CHECK("ts gated off", 1'b0, timestamp_gated)
    endtask

    // Aborted frame writes nothing; unmapped read gives zero
    task automatic t_abort;
        logic [7:0] q;
        host.frame(1'b0, adc_cfg_pkg::OFS_TIMESTAMP, 8'h03, 20, q);
        rd(adc_cfg_pkg::OFS_TIMESTAMP, q);
        `CHECK("abort", 8'h02, q)
        rd(15'h0050, q);
        `CHECK("unmapped", 8'h00, q)
    endtask

    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog well beyond the expected 31 us run
    initial
    begin
        #200000;
        fail_count++;
        close_out();
    end

    // Main sequence
    initial
    begin
        sysref_edge_position = 24'hA5_5A3C;
        timestamp_in = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        t_reset();
        t_noise();
        t_sysref();
        t_span();
        t_profile();
        t_timestamp();
        t_abort();
        close_out();
    end
endmodule // tb_top
`default_nettype wire
